// File: bps_sequencer.sv
// Board power sequencer top: supply enables, breaker, power-good and
// local reset logic, with a classic Wishbone register slave.
// Assumes all pin inputs are asynchronous levels; analog sense levels
// arrive as comparator outputs; open-drain pins are resolved outside.
`timescale 1ns/1ps
`default_nettype none
`include "bps_consts.svh"

//Contract
// - Off request held keeps supplies off.
// - Off request low starts gate and timer.
// - Blanking window ignores current faults entirely.
// - Breaker armed only after timer threshold.
// - Sustained overcurrent past delay trips, fault low.
// - Short circuit trips immediately when armed.
// - Both outputs good asserts board_n_a, reset follows.
// - Not board_n_a forces local reset asserted.
// - Power-down enables output discharge switches.
// - Power-down clears blanking timer immediately.
// - Power-down uses gate pull-down, charge off.
// - Power-down output loss drops board_n_a at once.
// - Trip latches until off request cycles.
// - Power-good released after loss deglitch delay.
// - Host reset low drives local reset low.
// - External fault low latches off after deglitch.
module bps_sequencer
	import bps_pkg::*;
#(
	parameter int TIMER_CYCLES = `BPS_TIMER_CYC,
	parameter int PGD_CYCLES   = `BPS_PGD_CYC
) (
	// Clock and reset
	input  wire logic        core_clk,
	input  wire logic        reset,
	// Wishbone slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	// Backplane control inputs
	input  wire logic        board_select_n,
	input  wire logic        host_reset_in,
	// Comparator inputs
	input  wire logic        oc_3v,
	input  wire logic        oc_5v,
	input  wire logic        sc_3v,
	input  wire logic        sc_5v,
	input  wire logic        good_3v,
	input  wire logic        good_5v,
	// Fault pin, open drain two-way
	input  wire logic        fault_i,
	output logic             fault_o,
	output logic             fault_oe_n,
	// Power-good pin, open drain
	input  wire logic        power_good_n_i,
	output logic             power_good_n_o,
	output logic             power_good_n_oe_n,
	// Local reset pin, open drain
	input  wire logic        local_reset_out_i,
	output logic             local_reset_out_o,
	output logic             local_reset_out_oe_n,
	// Analog switch enables
	input  wire logic        unused_tie_low,
	output logic             gate_charge_en,
	output logic             gate_pulldown_en,
	output logic             timer_charge_en,
	output logic             discharge_en,
	// Interrupt
	output logic             irq
);

	localparam logic [`BPS_CNT_W-1:0] TIMER_LAST = TIMER_CYCLES[`BPS_CNT_W-1:0] - 1'b1;

	// ------------------------------------------------------------------
	// Signals
	// ------------------------------------------------------------------
	logic [`BPS_SYNC_W-1:0] sync1_reg;
	logic [`BPS_SYNC_W-1:0] sync2_reg;
	logic                   bsel_s;
	logic                   hrst_s;
	logic                   oc3_s;
	logic                   oc5_s;
	logic                   sc3_s;
	logic                   sc5_s;
	logic                   g3_s;
	logic                   g5_s;
	logic                   fault_s;
	logic                   pgpin_s;
	logic                   lrpin_s;
	logic                   off_req;
	logic                   sc_any;
	logic                   pg_ok;
	logic                   oc_done;
	logic                   extf_done;
	logic                   pgloss_done;
	logic                   timer_done;
	logic                   soft_off_reg;
	logic                   pg_reg;
	logic                   pg_next;
	logic                   ack_reg;
	logic                   wr_stb;
	logic [`BPS_CNT_W-1:0]  timer_reg;
	logic [`BPS_EV_W-1:0]   irq_stat_reg;
	logic [`BPS_EV_W-1:0]   irq_en_reg;
	logic [`BPS_EV_W-1:0]   events;
	logic [`BPS_EV_W-1:0]   clr_mask;
	bps_state_t             state_reg;
	bps_state_t             state_next;
	bps_reg_t               sel_reg;

	// Address decode shared by read and write paths
	function automatic bps_reg_t reg_decode(input logic [7:0] adr);
		if (adr == `BPS_ADR_CTRL) begin
			return BPS_REG_CTRL;
		end else if (adr == `BPS_ADR_STATE) begin
			return BPS_REG_STATE;
		end else if (adr == `BPS_ADR_IRQ_STAT) begin
			return BPS_REG_IRQ_STAT;
		end else if (adr == `BPS_ADR_IRQ_EN) begin
			return BPS_REG_IRQ_EN;
		end else if (adr == `BPS_ADR_IRQ_CLR) begin
			return BPS_REG_IRQ_CLR;
		end else begin
			return BPS_REG_NONE;
		end
	endfunction

	// ------------------------------------------------------------------
	// Input synchronizers
	// ------------------------------------------------------------------
	// Two flops per input; only the second stage is read
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			sync1_reg <= `BPS_SYNC_RST;
			sync2_reg <= `BPS_SYNC_RST;
		end else begin
			sync1_reg <= {board_select_n, host_reset_in, oc_3v, oc_5v, sc_3v, sc_5v,
				good_3v, good_5v, fault_i, power_good_n_i, local_reset_out_i};
			sync2_reg <= sync1_reg;
		end
	end

	assign {bsel_s, hrst_s, oc3_s, oc5_s, sc3_s, sc5_s, g3_s, g5_s, fault_s, pgpin_s, lrpin_s} = sync2_reg;
	assign off_req = bsel_s | soft_off_reg;
	assign sc_any  = sc3_s | sc5_s;
	assign pg_ok   = g3_s & g5_s;

	// ------------------------------------------------------------------
	// Delay counters
	// ------------------------------------------------------------------
	// Overcurrent counts only while armed
	bps_deglitch #(.CYCLES(`BPS_TRIP_CYC)) u_oc_trip (
		.core_clk (core_clk),
		.reset    (reset),
		.level    ((oc3_s | oc5_s) && state_reg == BPS_ARMED),
		.done     (oc_done)
	);

	// Outside pull-down seen only while not driving the pin ourselves
	bps_deglitch #(.CYCLES(`BPS_EXTF_CYC)) u_ext_fault (
		.core_clk (core_clk),
		.reset    (reset),
		.level    (!fault_s && fault_oe_n),
		.done     (extf_done)
	);

	// Output loss qualified before power-good is released
	bps_deglitch #(.CYCLES(PGD_CYCLES)) u_pg_loss (
		.core_clk (core_clk),
		.reset    (reset),
		.level    (!pg_ok && pg_reg),
		.done     (pgloss_done)
	);

	// Blanking timer: cleared unless ramping or armed, counts in ramp
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			timer_reg <= '0;
		end else if (state_next == BPS_OFF || state_next == BPS_LATCHED) begin
			timer_reg <= '0;
		end else if (state_reg == BPS_RAMP && timer_reg != TIMER_LAST) begin
			timer_reg <= timer_reg + 1'b1;
		end
	end

	assign timer_done = (timer_reg == TIMER_LAST);

	// ------------------------------------------------------------------
	// Sequencer
	// ------------------------------------------------------------------
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			BPS_OFF: begin
				if (!off_req) begin
					state_next = BPS_RAMP;
				end
			end
			BPS_RAMP: begin
				if (extf_done) begin
					state_next = BPS_LATCHED;
				end else if (off_req) begin
					state_next = BPS_OFF;
				end else if (timer_done) begin
					state_next = BPS_ARMED;
				end
			end
			BPS_ARMED: begin
				if (sc_any || oc_done || extf_done) begin
					state_next = BPS_LATCHED;
				end else if (off_req) begin
					state_next = BPS_OFF;
				end
			end
			default: begin
				if (off_req) begin
					state_next = BPS_OFF;
				end
			end
		endcase
	end

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			state_reg <= BPS_OFF;
		end else begin
			state_reg <= state_next;
		end
	end

	// Analog enables and fault pin, registered from the next state
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			gate_charge_en   <= 1'b0;
			gate_pulldown_en <= 1'b1;
			timer_charge_en  <= 1'b0;
			discharge_en     <= 1'b1;
			fault_oe_n       <= 1'b1;
		end else begin
			gate_charge_en   <= (state_next == BPS_RAMP || state_next == BPS_ARMED);
			gate_pulldown_en <= (state_next == BPS_OFF || state_next == BPS_LATCHED);
			timer_charge_en  <= (state_next == BPS_RAMP);
			discharge_en     <= (state_next == BPS_OFF);
			fault_oe_n       <= (state_next != BPS_LATCHED);
		end
	end

	// ------------------------------------------------------------------
	// Power good and local reset
	// ------------------------------------------------------------------
	always_comb begin
		pg_next = pg_reg;
		if (state_reg == BPS_OFF && !pg_ok) begin
			pg_next = 1'b0;
		end else if (pgloss_done) begin
			pg_next = 1'b0;
		end else if (pg_ok && (state_reg == BPS_RAMP || state_reg == BPS_ARMED)) begin
			pg_next = 1'b1;
		end
	end

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			pg_reg               <= 1'b0;
			power_good_n_oe_n    <= 1'b1;
			local_reset_out_oe_n <= 1'b0;
		end else begin
			pg_reg               <= pg_next;
			power_good_n_oe_n    <= !pg_next;
			local_reset_out_oe_n <= pg_next && hrst_s;
		end
	end

	// Open-drain pins only ever pull low
	assign fault_o           = 1'b0;
	assign power_good_n_o    = 1'b0;
	assign local_reset_out_o = unused_tie_low & 1'b0;

	// ------------------------------------------------------------------
	// Interrupt status
	// ------------------------------------------------------------------
	assign events[`BPS_EV_OC_TRIP]   = state_reg == BPS_ARMED && state_next == BPS_LATCHED && oc_done && !sc_any;
	assign events[`BPS_EV_SC_TRIP]   = state_reg == BPS_ARMED && sc_any;
	// Ramp ignores current faults, so only the outside pull can latch there
	assign events[`BPS_EV_EXT_FAULT] = state_reg != BPS_LATCHED && state_next == BPS_LATCHED &&
		(state_reg == BPS_RAMP || (!oc_done && !sc_any));
	assign events[`BPS_EV_PG_RISE]   = pg_next && !pg_reg;
	assign events[`BPS_EV_PG_FALL]   = !pg_next && pg_reg;
	assign clr_mask = (wr_stb && reg_decode(wb_adr_i) == BPS_REG_IRQ_CLR) ? wb_dat_i[`BPS_EV_W-1:0] : '0;

	// Sticky bits; a new event wins over a clear in the same cycle
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			irq_stat_reg <= '0;
		end else begin
			irq_stat_reg <= (irq_stat_reg & ~clr_mask) | events;
		end
	end

	assign irq = |(irq_stat_reg & irq_en_reg);

	// ------------------------------------------------------------------
	// Wishbone slave
	// ------------------------------------------------------------------
	// Write lands on the edge where ack is seen high
	assign wr_stb   = wb_cyc_i && wb_stb_i && wb_we_i && ack_reg && wb_sel_i[0];
	assign wb_ack_o = ack_reg;

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			ack_reg <= 1'b0;
			sel_reg <= BPS_REG_NONE;
		end else begin
			ack_reg <= wb_cyc_i && wb_stb_i && !ack_reg;
			sel_reg <= reg_decode(wb_adr_i);
		end
	end

	// Writable registers
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			soft_off_reg <= `BPS_CTRL_RST;
			irq_en_reg   <= `BPS_IRQ_EN_RST;
		end else if (wr_stb) begin
			if (reg_decode(wb_adr_i) == BPS_REG_CTRL) begin
				soft_off_reg <= wb_dat_i[`BPS_CTRL_SOFT_OFF];
			end else if (reg_decode(wb_adr_i) == BPS_REG_IRQ_EN) begin
				irq_en_reg <= wb_dat_i[`BPS_EV_W-1:0];
			end
		end
	end

	// Read data captured on the request edge, unmapped reads zero
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			wb_dat_o <= '0;
		end else if (wb_cyc_i && wb_stb_i && !ack_reg) begin
			if (reg_decode(wb_adr_i) == BPS_REG_CTRL) begin
				wb_dat_o <= {31'h00000000, soft_off_reg};
			end else if (reg_decode(wb_adr_i) == BPS_REG_STATE) begin
				wb_dat_o <= {25'h0000000, lrpin_s, pgpin_s, fault_s, timer_done, pg_reg, state_reg};
			end else if (reg_decode(wb_adr_i) == BPS_REG_IRQ_STAT) begin
				wb_dat_o <= {27'h0000000, irq_stat_reg};
			end else if (reg_decode(wb_adr_i) == BPS_REG_IRQ_EN) begin
				wb_dat_o <= {27'h0000000, irq_en_reg};
			end else begin
				wb_dat_o <= '0;
			end
		end
	end

	// ------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (reset);

	sequence s_off_cycled;
		(state_reg == BPS_LATCHED && off_req) ##1 (state_reg == BPS_OFF && !off_req);
	endsequence

	a_off_holds: assert property (off_req |=> !gate_charge_en) else $error("gate on under off request");
	a_ramp_start: assert property (state_reg == BPS_OFF && !off_req |=> gate_charge_en && timer_charge_en)
		else $error("power-up not started");
	a_blank_ignore: assert property (state_reg == BPS_RAMP && !extf_done |=> fault_oe_n)
		else $error("fault during blanking");
	a_arm_timer: assert property ($rose(state_reg == BPS_ARMED) |-> $past(timer_done))
		else $error("armed before timer end");
	a_oc_trip: assert property (state_reg == BPS_ARMED && oc_done |=> !fault_oe_n && !gate_charge_en)
		else $error("overcurrent not tripped");
	a_sc_trip: assert property (state_reg == BPS_ARMED && sc_any |=> !fault_oe_n && gate_pulldown_en)
		else $error("short circuit not tripped");
	a_pg_assert: assert property (pg_ok && state_reg == BPS_ARMED && !pgloss_done |=> !power_good_n_oe_n)
		else $error("board_n_a not asserted");
	a_reset_hold: assert property (!pg_next || !hrst_s |=> !local_reset_out_oe_n)
		else $error("local reset not asserted");
	a_off_outputs: assert property (state_reg == BPS_OFF |-> discharge_en && gate_pulldown_en && timer_reg == '0)
		else $error("power-down outputs wrong");
	a_down_pg: assert property (state_reg == BPS_OFF && !pg_ok |=> power_good_n_oe_n)
		else $error("board_n_a held in power-down");
	a_latch_hold: assert property (state_reg == BPS_LATCHED && !off_req |=> state_reg == BPS_LATCHED)
		else $error("latch released early");
	a_latch_cycle: assert property (s_off_cycled |=> state_reg == BPS_RAMP)
		else $error("no restart after cycling");
	a_pg_deglitch: assert property (pg_reg && !pg_ok && state_reg != BPS_OFF && !pgloss_done |=> pg_reg)
		else $error("power-good dropped early");
	a_ext_latch: assert property (extf_done && state_reg == BPS_RAMP |=> state_reg == BPS_LATCHED)
		else $error("external fault not latched");

endmodule
`default_nettype wire

// File: bps_consts.svh
// Constants for the board power sequencer: offsets, field positions,
// reset values and timing counts.
// Assumes a 100 MHz core clock; included by its bare name.
`ifndef BPS_CONSTS_SVH
`define BPS_CONSTS_SVH

// ----------------------------------------------------------------------
// Clock and timing
// ----------------------------------------------------------------------
`define BPS_CLK_MHZ        100
`define BPS_TRIP_US        21
`define BPS_TRIP_CYC       (`BPS_TRIP_US * `BPS_CLK_MHZ)
`define BPS_EXTF_US        21
`define BPS_EXTF_CYC       (`BPS_EXTF_US * `BPS_CLK_MHZ)
`define BPS_PGD_US         50
`define BPS_PGD_CYC        (`BPS_PGD_US * `BPS_CLK_MHZ)
`define BPS_TIMER_US       2500
`define BPS_TIMER_CYC      (`BPS_TIMER_US * `BPS_CLK_MHZ)
`define BPS_CNT_W          24

// ----------------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------------
`define BPS_ADR_CTRL       8'h00
`define BPS_ADR_STATE      8'h04
`define BPS_ADR_IRQ_STAT   8'h08
`define BPS_ADR_IRQ_EN     8'h0c
`define BPS_ADR_IRQ_CLR    8'h10

// ----------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------
`define BPS_CTRL_SOFT_OFF  0
`define BPS_CTRL_RST       1'h0
`define BPS_IRQ_EN_RST     5'h00
`define BPS_EV_OC_TRIP     0
`define BPS_EV_SC_TRIP     1
`define BPS_EV_EXT_FAULT   2
`define BPS_EV_PG_RISE     3
`define BPS_EV_PG_FALL     4
`define BPS_EV_W           5
`define BPS_SYNC_W         11
`define BPS_SYNC_RST       11'h406

`endif

// File: bps_pkg.sv
// Types for the board power sequencer.
// Assumes nothing of its surroundings.
package bps_pkg;

	// ------------------------------------------------------------------
	// Sequencer states
	// ------------------------------------------------------------------
	typedef enum logic [1:0] {
		BPS_OFF,
		BPS_RAMP,
		BPS_ARMED,
		BPS_LATCHED
	} bps_state_t;

	// ------------------------------------------------------------------
	// Register selector
	// ------------------------------------------------------------------
	typedef enum logic [2:0] {
		BPS_REG_CTRL,
		BPS_REG_STATE,
		BPS_REG_IRQ_STAT,
		BPS_REG_IRQ_EN,
		BPS_REG_IRQ_CLR,
		BPS_REG_NONE
	} bps_reg_t;

endpackage

// File: bps_deglitch.sv
// Level qualifier: done rises once the level has held for CYCLES clocks.
// Assumes a level already synchronous to core_clk.
`timescale 1ns/1ps
`default_nettype none
`include "bps_consts.svh"

module bps_deglitch #(
	parameter int CYCLES = 1
) (
	// Clock and reset
	input  wire logic core_clk,
	input  wire logic reset,
	// Level in, qualified level out
	input  wire logic level,
	output logic      done
);

	localparam logic [`BPS_CNT_W-1:0] LIMIT = CYCLES[`BPS_CNT_W-1:0];

	logic [`BPS_CNT_W-1:0] cnt_reg;

	// ------------------------------------------------------------------
	// Count while held, restart on any drop
	// ------------------------------------------------------------------
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			cnt_reg <= '0;
		end else if (!level) begin
			cnt_reg <= '0;
		end else if (cnt_reg != LIMIT) begin
			cnt_reg <= cnt_reg + 1'b1;
		end
	end

	// Saturated count marks a qualified level
	assign done = (cnt_reg == LIMIT);

	a_deglitch_len: assert property (@(posedge core_clk) disable iff (reset)
		$rose(done) |-> $past(level)) else $error("qualified level without held input");

endmodule
`default_nettype wire

// File: bps_board_model.sv
// Board-side model: two supply rails behind the pass transistors and
// pull-ups on the three open-drain wires.
// Assumes the sequencer's enables are registered on core_clk.
`timescale 1ns/1ps
`default_nettype none

module bps_board_model (
	// Clock
	input  wire logic core_clk,
	// Sequencer drives
	input  wire logic gate_charge_en,
	input  wire logic fault_oe_n,
	input  wire logic power_good_n_oe_n,
	input  wire logic local_reset_out_oe_n,
	// Outside pull on the fault wire
	input  wire logic ext_fault,
	// Rail comparators and wire levels
	output logic      good_3v,
	output logic      good_5v,
	output logic      fault_i,
	output logic      power_good_n_i,
	output logic      local_reset_out_i
);
	logic [2:0] rail_reg = 3'h0;

	// Rails charge while the gate is driven, bleed otherwise
	always_ff @(posedge core_clk) begin
		if (gate_charge_en && rail_reg != 3'h6)
			rail_reg <= rail_reg + 3'h1;
		else if (!gate_charge_en && rail_reg != 3'h0)
			rail_reg <= rail_reg - 3'h1;
	end

	// Comparators; 5v rail is last up, first down
	assign good_3v = rail_reg >= 3'h5;
	assign good_5v = rail_reg == 3'h6;

	// Pull-ups win unless some party pulls low
	assign fault_i           = fault_oe_n & ~ext_fault;
	assign power_good_n_i    = power_good_n_oe_n;
	assign local_reset_out_i = local_reset_out_oe_n;
endmodule
`default_nettype wire

// File: bps_sequencer_tb.sv
// Self-checking bench for the board power sequencer.
// Assumes bps_board_model stands on the board side of the pins.
`timescale 1ns/1ps
`default_nettype none
`include "bps_consts.svh"

module bps_sequencer_tb
	import bps_pkg::*;
;
	localparam int TIMER = 20;
	logic        core_clk, reset, cyc, stb, we, host_reset_in, board_select_n;
	logic        oc_3v, oc_5v, sc_3v, sc_5v, ext_fault, ack, irq;
	logic        good_3v, good_5v, fault_i, fault_oe_n, pg_i, pg_oe_n, lr_i, lr_oe_n;
	logic        gate_charge_en, gate_pulldown_en, timer_charge_en, discharge_en;
	logic [7:0]  adr;
	logic [31:0] wdat, dat_o, rd;
	int          err_count = 0;
	int          checks_done = 0;
	int          cycles = 0;

	// ------------------------------------------------------------------
	// Design and board
	// ------------------------------------------------------------------
	bps_sequencer #(.TIMER_CYCLES(TIMER), .PGD_CYCLES(8)) DUT (
		.core_clk(core_clk), .reset(reset), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat),
		.wb_dat_o(dat_o), .wb_ack_o(ack), .board_select_n(board_select_n),
		.host_reset_in(host_reset_in), .oc_3v(oc_3v), .oc_5v(oc_5v),
		.sc_3v(sc_3v), .sc_5v(sc_5v), .good_3v(good_3v), .good_5v(good_5v),
		.fault_i(fault_i), .fault_o(), .fault_oe_n(fault_oe_n),
		.power_good_n_i(pg_i), .power_good_n_o(), .power_good_n_oe_n(pg_oe_n),
		.local_reset_out_i(lr_i), .local_reset_out_o(), .local_reset_out_oe_n(lr_oe_n),
		.unused_tie_low(1'b0), .gate_charge_en(gate_charge_en),
		.gate_pulldown_en(gate_pulldown_en), .timer_charge_en(timer_charge_en),
		.discharge_en(discharge_en), .irq(irq));

	bps_board_model board (
		.core_clk(core_clk), .gate_charge_en(gate_charge_en), .fault_oe_n(fault_oe_n),
		.power_good_n_oe_n(pg_oe_n), .local_reset_out_oe_n(lr_oe_n),
		.ext_fault(ext_fault), .good_3v(good_3v), .good_5v(good_5v), .fault_i(fault_i),
		.power_good_n_i(pg_i), .local_reset_out_i(lr_i));

	// ------------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			err_count++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// Classic single cycle; request held until the edge that samples ack high
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge core_clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		do begin
			@(posedge core_clk);
			n++;
		end while (ack !== 1'b1 && n < 20);
		if (n >= 20)
			err_count++;
		rd = dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask

	task automatic state_is(input bps_state_t s);
		wb(1'b0, `BPS_ADR_STATE, 32'h0);
		check(rd & 32'h3, {30'h0, s});
	endtask

	function automatic logic [31:0] ens();
		return {28'h0, gate_charge_en, gate_pulldown_en, timer_charge_en, discharge_en};
	endfunction

	// ------------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------------
	task automatic t_reset;
		check(ens(), 32'h5);
		check({30'h0, pg_oe_n, lr_oe_n}, 32'h2);
		wb(1'b1, 8'h14, 32'hffffffff);
		wb(1'b0, 8'h14, 32'h0);
		check(rd, 32'h0);
		wb(1'b0, `BPS_ADR_IRQ_EN, 32'h0);
		check(rd, {27'h0, `BPS_IRQ_EN_RST});
		tick(40);
		check(ens(), 32'h5);
		state_is(BPS_OFF);
		$display("test reset done");
	endtask

	task automatic t_ramp;
		@(posedge core_clk);
		board_select_n <= 1'b0;
		sc_5v <= 1'b1;
		oc_3v <= 1'b1;
		tick(6);
		check(ens(), 32'ha);
		check(fault_oe_n, 1'b1);
		@(posedge core_clk);
		sc_5v <= 1'b0;
		oc_3v <= 1'b0;
		tick(TIMER + 10);
		state_is(BPS_ARMED);
		check(ens(), 32'h8);
		check({30'h0, pg_oe_n, lr_oe_n}, 32'h1);
		@(posedge core_clk);
		host_reset_in <= 1'b0;
		tick(4);
		check(lr_oe_n, 1'b0);
		@(posedge core_clk);
		host_reset_in <= 1'b1;
		tick(4);
		check(lr_oe_n, 1'b1);
		$display("test ramp done");
	endtask

	task automatic t_short;
		wb(1'b1, `BPS_ADR_IRQ_EN, 32'h2);
		@(posedge core_clk);
		sc_5v <= 1'b1;
		tick(3);
		check({fault_oe_n, gate_charge_en, irq}, 3'h1);
		@(posedge core_clk);
		sc_5v <= 1'b0;
		tick(30);
		check({30'h0, pg_oe_n, lr_oe_n}, 32'h2);
		state_is(BPS_LATCHED);
		wb(1'b0, `BPS_ADR_IRQ_STAT, 32'h0);
		check(rd, 32'h1a);
		wb(1'b1, `BPS_ADR_IRQ_EN, 32'h0);
		tick(1);
		check(irq, 1'b0);
		wb(1'b1, `BPS_ADR_IRQ_EN, 32'h2);
		wb(1'b1, `BPS_ADR_IRQ_CLR, 32'h2);
		tick(1);
		check(irq, 1'b0);
		wb(1'b0, `BPS_ADR_IRQ_STAT, 32'h0);
		check(rd, 32'h18);
		@(posedge core_clk);
		board_select_n <= 1'b1;
		tick(4);
		check(ens(), 32'h5);
		state_is(BPS_OFF);
		$display("test short done");
	endtask

	task automatic t_oc;
		@(posedge core_clk);
		board_select_n <= 1'b0;
		tick(TIMER + 12);
		@(posedge core_clk);
		oc_3v <= 1'b1;
		tick(2000);
		@(posedge core_clk);
		oc_3v <= 1'b0;
		tick(5);
		state_is(BPS_ARMED);
		@(posedge core_clk);
		oc_5v <= 1'b1;
		tick(2110);
		check({fault_oe_n, gate_charge_en, gate_pulldown_en}, 3'h1);
		@(posedge core_clk);
		oc_5v <= 1'b0;
		board_select_n <= 1'b1;
		tick(5);
		@(posedge core_clk);
		board_select_n <= 1'b0;
		tick(TIMER + 12);
		state_is(BPS_ARMED);
		$display("test overcurrent done");
	endtask

	task automatic t_down;
		@(posedge core_clk);
		board_select_n <= 1'b1;
		tick(4);
		check(ens(), 32'h5);
		tick(12);
		check({30'h0, pg_oe_n, lr_oe_n}, 32'h2);
		$display("test power-down done");
	endtask

	task automatic t_ext;
		wb(1'b1, `BPS_ADR_IRQ_CLR, 32'h1f);
		@(posedge core_clk);
		board_select_n <= 1'b0;
		tick(TIMER + 12);
		@(posedge core_clk);
		ext_fault <= 1'b1;
		tick(2000);
		state_is(BPS_ARMED);
		tick(110);
		state_is(BPS_LATCHED);
		wb(1'b0, `BPS_ADR_IRQ_STAT, 32'h0);
		check(rd & 32'h7, 32'h4);
		@(posedge core_clk);
		ext_fault <= 1'b0;
		wb(1'b1, `BPS_ADR_CTRL, 32'h1);
		tick(4);
		state_is(BPS_OFF);
		wb(1'b0, `BPS_ADR_CTRL, 32'h0);
		check(rd, 32'h1);
		$display("test external fault done");
	endtask

	task automatic results;
		$display("checks %0d, mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// ------------------------------------------------------------------
	// Clock, watchdog and main sequence
	// ------------------------------------------------------------------
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end

	// Cut a hang short
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 20000) begin
			err_count++;
			results;
		end
	end

	initial begin
		{reset, board_select_n, host_reset_in} = 3'h7;
		{cyc, stb, we, oc_3v, oc_5v, sc_3v, sc_5v, ext_fault} = 8'h0;
		adr = 8'h0;
		wdat = 32'h0;
		repeat (5) @(posedge core_clk);
		reset <= 1'b0;
		tick(1);
		t_reset;
		t_ramp;
		t_short;
		t_oc;
		t_down;
		t_ext;
		results;
	end
endmodule
`default_nettype wire
